// ### src/ssr_sync_router.sv
// sync signal router between front panel and backplane sync lines
// Notes on behaviour
// - front-to-backplane route passes front sync onto the backplane line
// - backplane-to-front route passes backplane sync onto front connectors
// - drive select none: own sync goes nowhere
// - drive select both: own sync on front and backplane together
// - drive select front only: own sync on front, never on backplane
// - drive select backplane only: own sync on backplane, never on front
// - route selection is held and read back unchanged
// - drive selection is held and read back unchanged
// - sync clock comes from front, backplane or divided sample clock
`default_nettype none
module ssr_sync_router
  import ssr_pkg::*;
(
  input  wire logic       clk_sys,           // system clock, 25 MHz
  input  wire logic       rst_n,             // async reset, active low
  input  wire logic       en,                // clock enable, freezes state
  input  wire logic       routeWrite,        // route select write strobe
  input  wire logic [1:0] routeValue,        // route select value
  input  wire logic       driveWrite,        // drive select write strobe
  input  wire logic [3:0] driveValue,        // drive select value
  input  wire logic       clockWrite,        // clock source write strobe
  input  wire logic [2:0] clockValue,        // clock source value
  input  wire logic       syncOwn,           // module's own sync level
  input  wire logic       frontSyncIn,       // front sync pin level
  input  wire logic       backplaneSyncIn,   // backplane sync pin level
  input  wire logic       frontClkIn,        // front panel clock level
  input  wire logic       backplaneClkIn,    // backplane clock level
  output var  logic       frontSyncOut,      // front sync drive value
  output var  logic       frontSyncOe_n,     // front sync enable, low drives
  output var  logic       backplaneSyncOut,  // backplane sync drive value
  output var  logic       backplaneSyncOe_n, // backplane enable, low drives
  output var  logic [1:0] routeReadback,     // current route select
  output var  logic [3:0] driveReadback,     // current drive select
  output var  logic [2:0] clockReadback,     // current clock source
  output var  logic       syncClk            // selected sync clock level
);

  ssr_cfg_s cfg_reg;
  ssr_cfg_s cfg_next;
  ssr_pin_s pin_reg;
  ssr_pin_s pin_next;
  logic     driveFront;
  logic     driveBack;
  logic     bridgeToFront;
  logic     bridgeToBack;

  // selection state; illegal codes are dropped so readback stays legal
  always_comb begin
    cfg_next = cfg_reg;
    if (en && routeWrite) begin
      case (routeValue)
        ROUTE_FRONT_TO_BACKPLANE,
        ROUTE_BACKPLANE_TO_FRONT: cfg_next.route = ssr_route_e'(routeValue);
        default:                  cfg_next.route = cfg_reg.route;
      endcase
    end
    if (en && driveWrite) begin
      case (driveValue)
        SYNC_DRIVE_NONE,
        SYNC_DRIVE_BOTH,
        SYNC_DRIVE_FRONT_ONLY,
        SYNC_DRIVE_BACKPLANE_ONLY: cfg_next.drive = ssr_drive_e'(driveValue);
        default:                   cfg_next.drive = cfg_reg.drive;
      endcase
    end
    if (en && clockWrite) begin
      case (clockValue)
        CLK_SOURCE_FRONT,
        CLK_SOURCE_BACKPLANE,
        DIVIDED_SAMPLE_CLOCK_SOURCE:
          cfg_next.clkSrc = ssr_clksrc_e'(clockValue);
        default:                     cfg_next.clkSrc = cfg_reg.clkSrc;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= '{SSR_ROUTE_RESET, SSR_DRIVE_RESET, SSR_CLKSRC_RESET};
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // pins are decoded from the next selection so a write acts on the
  // same edge that stores it, avoiding one stale cycle on the lines
  always_comb begin
    driveFront    = 1'b0;
    driveBack     = 1'b0;
    case (cfg_next.drive)
      SYNC_DRIVE_NONE: begin
        driveFront = 1'b0;
        driveBack  = 1'b0;
      end
      SYNC_DRIVE_BOTH: begin
        driveFront = 1'b1;
        driveBack  = 1'b1;
      end
      SYNC_DRIVE_FRONT_ONLY: begin
        driveFront = 1'b1;
        driveBack  = 1'b0;
      end
      SYNC_DRIVE_BACKPLANE_ONLY: begin
        driveFront = 1'b0;
        driveBack  = 1'b1;
      end
      default: begin
        driveFront = 1'b0;
        driveBack  = 1'b0;
      end
    endcase
    bridgeToBack  = (cfg_next.route == ROUTE_FRONT_TO_BACKPLANE);
    bridgeToFront = (cfg_next.route == ROUTE_BACKPLANE_TO_FRONT);
    pin_next = pin_reg;
    if (en) begin
      // bridged level and own sync share a pin as a wired OR
      pin_next.frontOut      = (driveFront & syncOwn)
                             | (bridgeToFront & backplaneSyncIn);
      pin_next.frontOe_n     = ~(driveFront | bridgeToFront);
      pin_next.backplaneOut  = (driveBack & syncOwn)
                             | (bridgeToBack & frontSyncIn);
      pin_next.backplaneOe_n = ~(driveBack | bridgeToBack);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg <= SSR_PIN_RESET;
    end else begin
      pin_reg <= pin_next;
    end
  end

  ssr_clock_select u_clock_select (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .en       (en),
    .clkSrc   (cfg_reg.clkSrc),
    .frontClk (frontClkIn),
    .backClk  (backplaneClkIn),
    .syncClk  (syncClk)
  );

  assign frontSyncOut      = pin_reg.frontOut;
  assign frontSyncOe_n     = pin_reg.frontOe_n;
  assign backplaneSyncOut  = pin_reg.backplaneOut;
  assign backplaneSyncOe_n = pin_reg.backplaneOe_n;
  assign routeReadback     = cfg_reg.route;
  assign driveReadback     = cfg_reg.drive;
  assign clockReadback     = cfg_reg.clkSrc;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  front_to_back_a: assert property (
    en && cfg_next.route == ROUTE_FRONT_TO_BACKPLANE && frontSyncIn
      |=> !backplaneSyncOe_n && backplaneSyncOut)
    else $error("front sync not bridged to backplane");

  back_to_front_a: assert property (
    en && cfg_next.route == ROUTE_BACKPLANE_TO_FRONT && backplaneSyncIn
      |=> !frontSyncOe_n && frontSyncOut)
    else $error("backplane sync not bridged to front");

  drive_none_a: assert property (
    en && cfg_next.drive == SYNC_DRIVE_NONE && !frontSyncIn
      && !backplaneSyncIn |=> !frontSyncOut && !backplaneSyncOut)
    else $error("own sync driven while drive select is none");

  drive_both_a: assert property (
    en && cfg_next.drive == SYNC_DRIVE_BOTH && syncOwn
      |=> frontSyncOut && backplaneSyncOut
          && !frontSyncOe_n && !backplaneSyncOe_n)
    else $error("own sync missing on one of both lines");

  front_only_a: assert property (
    en && cfg_next.drive == SYNC_DRIVE_FRONT_ONLY
      && cfg_next.route == ROUTE_FRONT_TO_BACKPLANE && !frontSyncIn
      |=> !frontSyncOe_n && frontSyncOut == $past(syncOwn)
          && !backplaneSyncOut)
    else $error("front only drive leaks to backplane");

  back_only_a: assert property (
    en && cfg_next.drive == SYNC_DRIVE_BACKPLANE_ONLY
      && cfg_next.route == ROUTE_BACKPLANE_TO_FRONT && !backplaneSyncIn
      |=> !backplaneSyncOe_n && backplaneSyncOut == $past(syncOwn)
          && !frontSyncOut)
    else $error("backplane only drive leaks to front");

  route_readback_a: assert property (
    en && routeWrite && (routeValue == ROUTE_FRONT_TO_BACKPLANE
      || routeValue == ROUTE_BACKPLANE_TO_FRONT)
      |=> routeReadback == $past(routeValue))
    else $error("route readback differs from value written");

  drive_readback_a: assert property (
    en && driveWrite && $onehot(driveValue)
      |=> driveReadback == $past(driveValue))
    else $error("drive readback differs from value written");

  clock_readback_a: assert property (
    en && clockWrite && $onehot(clockValue)
      |=> clockReadback == $past(clockValue))
    else $error("clock source readback differs from value written");

  select_hold_a: assert property (
    !(en && (routeWrite || driveWrite))
      |=> $stable(routeReadback) && $stable(driveReadback))
    else $error("selection changed without a write");

  pins_frozen_a: assert property (
    !en |=> $stable(frontSyncOut) && $stable(backplaneSyncOut)
            && $stable(frontSyncOe_n) && $stable(backplaneSyncOe_n))
    else $error("pins changed while clock enable low");

  route_swap_c: cover property (
    en && routeWrite && routeValue == ROUTE_BACKPLANE_TO_FRONT
      ##1 en && routeWrite && routeValue == ROUTE_FRONT_TO_BACKPLANE);

  drive_both_c: cover property (
    en && driveWrite && driveValue == SYNC_DRIVE_BOTH ##1 en && syncOwn);

  divided_clock_c: cover property (
    en && clockWrite && clockValue == DIVIDED_SAMPLE_CLOCK_SOURCE);

endmodule : ssr_sync_router
`default_nettype wire

// ### src/ssr_pkg.sv
// constants, enums and carriers shared by the sync router files
`default_nettype none
package ssr_pkg;

  typedef enum logic [1:0] {
    ROUTE_FRONT_TO_BACKPLANE = 2'h1,
    ROUTE_BACKPLANE_TO_FRONT = 2'h2
  } ssr_route_e;

  typedef enum logic [3:0] {
    SYNC_DRIVE_NONE           = 4'h1,
    SYNC_DRIVE_BOTH           = 4'h2,
    SYNC_DRIVE_FRONT_ONLY     = 4'h4,
    SYNC_DRIVE_BACKPLANE_ONLY = 4'h8
  } ssr_drive_e;

  typedef enum logic [2:0] {
    CLK_SOURCE_FRONT            = 3'h1,
    CLK_SOURCE_BACKPLANE        = 3'h2,
    DIVIDED_SAMPLE_CLOCK_SOURCE = 3'h4
  } ssr_clksrc_e;

  typedef struct packed {
    ssr_route_e  route;
    ssr_drive_e  drive;
    ssr_clksrc_e clkSrc;
  } ssr_cfg_s;

  typedef struct packed {
    logic frontOut;
    logic frontOe_n;
    logic backplaneOut;
    logic backplaneOe_n;
  } ssr_pin_s;

  localparam ssr_route_e  SSR_ROUTE_RESET  = ROUTE_FRONT_TO_BACKPLANE;
  localparam ssr_drive_e  SSR_DRIVE_RESET  = SYNC_DRIVE_NONE;
  localparam ssr_clksrc_e SSR_CLKSRC_RESET = DIVIDED_SAMPLE_CLOCK_SOURCE;
  localparam ssr_pin_s    SSR_PIN_RESET    = 4'h5;

  // half period of the divided sample clock, in clk_sys cycles
  localparam int unsigned SSR_DIV_WIDTH       = 4;
  localparam logic [3:0]  SSR_DIV_HALF_PERIOD = 4'h4;
  localparam logic [3:0]  SSR_DIV_ONE         = 4'h1;

endpackage : ssr_pkg
`default_nettype wire

// ### src/ssr_clock_select.sv
// sync clock source selector with built-in divider of the sample clock
`default_nettype none
module ssr_clock_select
  import ssr_pkg::*;
(
  input  wire logic        clk_sys,    // system clock, 25 MHz
  input  wire logic        rst_n,      // async reset, active low
  input  wire logic        en,         // clock enable, freezes state
  input  wire ssr_clksrc_e clkSrc,     // selected source
  input  wire logic        frontClk,   // front panel clock level
  input  wire logic        backClk,    // backplane clock level
  output var  logic        syncClk     // selected sync clock level
);

  logic [SSR_DIV_WIDTH-1:0] divCount_reg;
  logic [SSR_DIV_WIDTH-1:0] divCount_next;
  logic                     divClk_reg;
  logic                     divClk_next;
  logic                     syncClk_reg;
  logic                     syncClk_next;

  always_comb begin
    divCount_next = divCount_reg;
    divClk_next   = divClk_reg;
    syncClk_next  = syncClk_reg;
    if (en) begin
      if (divCount_reg == SSR_DIV_HALF_PERIOD - SSR_DIV_ONE) begin
        divCount_next = '0;
        divClk_next   = ~divClk_reg;
      end else begin
        divCount_next = divCount_reg + SSR_DIV_ONE;
      end
      case (clkSrc)
        CLK_SOURCE_FRONT:            syncClk_next = frontClk;
        CLK_SOURCE_BACKPLANE:        syncClk_next = backClk;
        DIVIDED_SAMPLE_CLOCK_SOURCE: syncClk_next = divClk_reg;
        default:                     syncClk_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divCount_reg <= '0;
      divClk_reg   <= 1'b0;
      syncClk_reg  <= 1'b0;
    end else begin
      divCount_reg <= divCount_next;
      divClk_reg   <= divClk_next;
      syncClk_reg  <= syncClk_next;
    end
  end

  assign syncClk = syncClk_reg;

  clk_front_pick_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    en && clkSrc == CLK_SOURCE_FRONT |=> syncClk == $past(frontClk))
    else $error("sync clock does not follow front clock");

  clk_divider_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    en && clkSrc == DIVIDED_SAMPLE_CLOCK_SOURCE
      |=> syncClk == $past(divClk_reg))
    else $error("sync clock does not follow divided clock");

endmodule : ssr_clock_select
`default_nettype wire

// ### test/ssr_sync_peer.sv
// peer modules sharing the front and backplane sync lines
`default_nettype none
module ssr_sync_peer (
  input  wire logic frontOut,  // router front value
  input  wire logic frontOe_n, // router front enable, low drives
  input  wire logic backOut,   // router backplane value
  input  wire logic backOe_n,  // router backplane enable, low drives
  input  wire logic peerFront, // peer pulls front low
  input  wire logic peerBack,  // peer pulls backplane low
  output var  logic frontWire, // front line level
  output var  logic backWire   // backplane line level
);
  timeunit 1ns;
  timeprecision 1ns;
  // pulled-up lines, any party pulls low: contention never reads as X
  always_comb begin
    frontWire = (frontOe_n | frontOut) & ~peerFront;
    backWire  = (backOe_n | backOut) & ~peerBack;
  end
endmodule : ssr_sync_peer
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for the sync router
`default_nettype none
module tb_top
  import ssr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0, rst_n = 1'b0, en = 1'b0, syncOwn = 1'b0;
  logic       routeWrite = 1'b0, driveWrite = 1'b0, clockWrite = 1'b0;
  logic [1:0] routeValue = 2'h1;
  logic [3:0] driveValue = 4'h1;
  logic [2:0] clockValue = 3'h4;
  logic       peerFront = 1'b0, peerBack = 1'b0;
  logic       frontClkIn = 1'b0, backplaneClkIn = 1'b0;
  logic       frontSyncIn, backplaneSyncIn, frontSyncOut, frontSyncOe_n;
  logic       backplaneSyncOut, backplaneSyncOe_n, syncClk;
  logic [1:0] routeReadback;
  logic [3:0] driveReadback;
  logic [2:0] clockReadback;
  ssr_route_e routeExp = SSR_ROUTE_RESET;
  ssr_drive_e driveExp = SSR_DRIVE_RESET;
  int         badCount = 0, samplesChecked = 0;

  always #20 clk_sys = ~clk_sys;

  ssr_sync_router i_dut (
    .clk_sys, .rst_n, .en, .routeWrite, .routeValue, .driveWrite,
    .driveValue, .clockWrite, .clockValue, .syncOwn, .frontSyncIn,
    .backplaneSyncIn, .frontClkIn, .backplaneClkIn, .frontSyncOut,
    .frontSyncOe_n, .backplaneSyncOut, .backplaneSyncOe_n, .routeReadback,
    .driveReadback, .clockReadback, .syncClk
  );
  ssr_sync_peer i_peer (
    .frontOut(frontSyncOut), .frontOe_n(frontSyncOe_n),
    .backOut(backplaneSyncOut), .backOe_n(backplaneSyncOe_n),
    .peerFront, .peerBack, .frontWire(frontSyncIn),
    .backWire(backplaneSyncIn)
  );

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic printVerdict;
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : printVerdict

  // levels are taken just after the stimulus settles, as the edge sees them
  task automatic step;
    logic f, b, o, fEn, bEn, fBr;
    #1;
    f = frontSyncIn;
    b = backplaneSyncIn;
    o = syncOwn;
    fEn = driveExp inside {SYNC_DRIVE_BOTH, SYNC_DRIVE_FRONT_ONLY};
    bEn = driveExp inside {SYNC_DRIVE_BOTH, SYNC_DRIVE_BACKPLANE_ONLY};
    fBr = routeExp == ROUTE_BACKPLANE_TO_FRONT;
    @(negedge clk_sys);
    check("front", {frontSyncOe_n, frontSyncOut & ~frontSyncOe_n},
          {~(fEn | fBr), (fEn & o) | (fBr & b)});
    check("back", {backplaneSyncOe_n, backplaneSyncOut & ~backplaneSyncOe_n},
          {~(bEn | ~fBr), (bEn & o) | (~fBr & f)});
    check("route", routeReadback, routeExp);
    check("drive", driveReadback, driveExp);
  endtask : step

  task automatic setSel(input logic [1:0] r, input logic [3:0] d);
    routeWrite = 1'b1;
    routeValue = r;
    driveWrite = 1'b1;
    driveValue = d;
    if (r inside {2'h1, 2'h2}) routeExp = ssr_route_e'(r);
    if (d inside {4'h1, 4'h2, 4'h4, 4'h8}) driveExp = ssr_drive_e'(d);
    step();
    routeWrite = 1'b0;
    driveWrite = 1'b0;
    // strobes stay low for one edge so a following call never re-raises
    // them in the same time step
    step();
  endtask : setSel

  task automatic tReset;
    rst_n = 1'b0;
    routeExp = SSR_ROUTE_RESET;
    driveExp = SSR_DRIVE_RESET;
    @(negedge clk_sys);
    check("rst route", routeReadback, SSR_ROUTE_RESET);
    check("rst drive", driveReadback, SSR_DRIVE_RESET);
    check("rst clk", clockReadback, SSR_CLKSRC_RESET);
    check("rst oe", {frontSyncOe_n, backplaneSyncOe_n}, 8'h03);
    rst_n = 1'b1;
    en = 1'b1;
  endtask : tReset

  task automatic tRouteDrive;
    for (int j = 1; j < 3; j++) begin
      for (int i = 0; i < 4; i++) begin
        setSel(j[1:0], 4'h1 << i);
        for (int k = 0; k < 8; k++) begin
          syncOwn = k[0];
          peerFront = k[1];
          peerBack = k[2];
          step();
        end
      end
    end
    setSel(2'h0, 4'h0);
    setSel(2'h3, 4'hC);
  endtask : tRouteDrive

  // clock enable low must hold off a write
  task automatic tFreeze;
    en = 1'b0;
    routeWrite = 1'b1;
    routeValue = ~routeExp;
    @(negedge clk_sys);
    check("frozen", routeReadback, routeExp);
    routeWrite = 1'b0;
    en = 1'b1;
    step();
  endtask : tFreeze

  task automatic tClock;
    int   flips;
    logic last;
    for (int s = 0; s < 3; s++) begin
      clockWrite = 1'b1;
      clockValue = 3'h1 << s;
      @(negedge clk_sys);
      clockWrite = 1'b0;
      check("clk sel", clockReadback, clockValue);
      for (int k = 0; k < 4 && s < 2; k++) begin
        frontClkIn = k[0];
        backplaneClkIn = ~k[0];
        @(negedge clk_sys);
        check("sync clk", syncClk, s[0] ^ k[0]);
      end
    end
    @(negedge clk_sys);
    last = syncClk;
    flips = 0;
    repeat (16) begin
      @(negedge clk_sys);
      flips += int'(syncClk !== last);
      last = syncClk;
    end
    check("div flips", flips[7:0], 8'(16 / SSR_DIV_HALF_PERIOD));
    // an illegal source code must leave the stored source alone
    clockWrite = 1'b1;
    clockValue = 3'h3;
    @(negedge clk_sys);
    clockWrite = 1'b0;
    check("clk bad", clockReadback, DIVIDED_SAMPLE_CLOCK_SOURCE);
  endtask : tClock

  initial begin
    #(40 * 1500);
    badCount++;
    printVerdict();
  end

  initial begin
    repeat (10) @(negedge clk_sys);
    tReset();
    step();
    tRouteDrive();
    setSel(2'h1, 4'h2);
    tFreeze();
    tClock();
    tReset();
    step();
    printVerdict();
  end
endmodule : tb_top
`default_nettype wire
